/* File: ipr_regs.vh */
`ifndef IPR_REGS_VH
`define IPR_REGS_VH

// Register byte offsets, one aligned 32-bit word each
`define IPR_OFF_EXT_INT1        12'h000
`define IPR_OFF_TMR4_OC4_OC3    12'h004
`define IPR_OFF_UART2_EXT2_TMR5 12'h008
`define IPR_OFF_SPI2            12'h00C
`define IPR_OFF_ICAP5_4_3       12'h010
`define IPR_OFF_OCMP5           12'h014
`define IPR_OFF_PARALLEL_PORT   12'h018

// Register index, matching the offset order above
`define IPR_IDX_EXT_INT1        3'h0
`define IPR_IDX_TMR4_OC4_OC3    3'h1
`define IPR_IDX_UART2_EXT2_TMR5 3'h2
`define IPR_IDX_SPI2            3'h3
`define IPR_IDX_ICAP5_4_3       3'h4
`define IPR_IDX_OCMP5           3'h5
`define IPR_IDX_PARALLEL_PORT   3'h6

// Number of priority fields and field width
`define IPR_NUM_FIELDS          15
`define IPR_PRIO_W              3
`define IPR_NUM_REGS            7

// Field reset pattern and disabled code
`define IPR_PRIO_RST            3'h4
`define IPR_PRIO_OFF            3'h0

// Field low bit positions inside their register
`define IPR_LSB_EXT_INT1        4'h0
`define IPR_LSB_TIMER4          4'hC
`define IPR_LSB_OCMP4           4'h8
`define IPR_LSB_OCMP3           4'h4
`define IPR_LSB_UART2_TX        4'hC
`define IPR_LSB_UART2_RX        4'h8
`define IPR_LSB_EXT_INT2        4'h4
`define IPR_LSB_TIMER5          4'h0
`define IPR_LSB_SPI2_EVENT      4'h4
`define IPR_LSB_SPI2_FAULT      4'h0
`define IPR_LSB_ICAP5           4'hC
`define IPR_LSB_ICAP4           4'h8
`define IPR_LSB_ICAP3           4'h4
`define IPR_LSB_OCMP5           4'h4
`define IPR_LSB_PARALLEL_PORT   4'h4

// Implemented bits and reset values per register
`define IPR_MASK_EXT_INT1       16'h0007
`define IPR_MASK_TMR4_OC4_OC3   16'h7770
`define IPR_MASK_UART2_EXT2_TMR5 16'h7777
`define IPR_MASK_SPI2           16'h0077
`define IPR_MASK_ICAP5_4_3      16'h7770
`define IPR_MASK_OCMP5          16'h0070
`define IPR_MASK_PARALLEL_PORT  16'h0070
`define IPR_RST_EXT_INT1        16'h0004
`define IPR_RST_TMR4_OC4_OC3    16'h4440
`define IPR_RST_UART2_EXT2_TMR5 16'h4444
`define IPR_RST_SPI2            16'h0044
`define IPR_RST_ICAP5_4_3       16'h4440
`define IPR_RST_OCMP5           16'h0040
`define IPR_RST_PARALLEL_PORT   16'h0040

`endif

/* File: ipr_top.v */
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "ipr_regs.vh"

module ipr_top
#(
	parameter ADDR_W = 12
)
(
	// Clock and reset
	input  wire                SYS_CLK,
	input  wire                SYS_RST,
	// APB slave side
	input  wire                PSEL,
	input  wire                PENABLE,
	input  wire                PWRITE,
	input  wire [ADDR_W-1:0]   PADDR,
	input  wire [31:0]         PWDATA,
	input  wire [3:0]          PSTRB,
	output wire                PREADY,
	output wire [31:0]         PRDATA,
	output wire                PSLVERR,
	// Source flags and gated requests
	input  wire [14:0]         SRC_FLAG,
	output wire [14:0]         SRC_REQ,
	// Priority codes to the arbitration logic
	output wire [2:0]          EXT_INT1_PRIO,
	output wire [2:0]          TIMER4_PRIO,
	output wire [2:0]          OCMP4_PRIO,
	output wire [2:0]          OCMP3_PRIO,
	output wire [2:0]          UART2_TX_PRIO,
	output wire [2:0]          UART2_RX_PRIO,
	output wire [2:0]          EXT_INT2_PRIO,
	output wire [2:0]          TIMER5_PRIO,
	output wire [2:0]          SPI2_EVENT_PRIO,
	output wire [2:0]          SPI2_FAULT_PRIO,
	output wire [2:0]          ICAP5_PRIO,
	output wire [2:0]          ICAP4_PRIO,
	output wire [2:0]          ICAP3_PRIO,
	output wire [2:0]          OCMP5_PRIO,
	output wire [2:0]          PARALLEL_PORT_PRIO
);

	// Register holding each field
	function [2:0] fld_reg;
		input [3:0] k;
		begin
			case (k)
				// External interrupt 1 word
				4'h0:    fld_reg = `IPR_IDX_EXT_INT1;
				// Timer 4 and compare 4, 3 word
				4'h1:    fld_reg = `IPR_IDX_TMR4_OC4_OC3;
				4'h2:    fld_reg = `IPR_IDX_TMR4_OC4_OC3;
				4'h3:    fld_reg = `IPR_IDX_TMR4_OC4_OC3;
				// Uart 2, external 2 and timer 5 word
				4'h4:    fld_reg = `IPR_IDX_UART2_EXT2_TMR5;
				4'h5:    fld_reg = `IPR_IDX_UART2_EXT2_TMR5;
				4'h6:    fld_reg = `IPR_IDX_UART2_EXT2_TMR5;
				4'h7:    fld_reg = `IPR_IDX_UART2_EXT2_TMR5;
				// Spi 2 word
				4'h8:    fld_reg = `IPR_IDX_SPI2;
				4'h9:    fld_reg = `IPR_IDX_SPI2;
				// Capture 5, 4, 3 word
				4'hA:    fld_reg = `IPR_IDX_ICAP5_4_3;
				4'hB:    fld_reg = `IPR_IDX_ICAP5_4_3;
				4'hC:    fld_reg = `IPR_IDX_ICAP5_4_3;
				// Compare 5 word
				4'hD:    fld_reg = `IPR_IDX_OCMP5;
				// Parallel port word
				default: fld_reg = `IPR_IDX_PARALLEL_PORT;
			endcase
		end
	endfunction

	// Low bit of each field inside its register
	function [3:0] fld_lsb;
		input [3:0] k;
		begin
			case (k)
				// External interrupt 1 word
				4'h0:    fld_lsb = `IPR_LSB_EXT_INT1;
				// Timer 4 and compare 4, 3 word
				4'h1:    fld_lsb = `IPR_LSB_TIMER4;
				4'h2:    fld_lsb = `IPR_LSB_OCMP4;
				4'h3:    fld_lsb = `IPR_LSB_OCMP3;
				// Uart 2, external 2 and timer 5 word
				4'h4:    fld_lsb = `IPR_LSB_UART2_TX;
				4'h5:    fld_lsb = `IPR_LSB_UART2_RX;
				4'h6:    fld_lsb = `IPR_LSB_EXT_INT2;
				4'h7:    fld_lsb = `IPR_LSB_TIMER5;
				// Spi 2 word
				4'h8:    fld_lsb = `IPR_LSB_SPI2_EVENT;
				4'h9:    fld_lsb = `IPR_LSB_SPI2_FAULT;
				// Capture 5, 4, 3 word
				4'hA:    fld_lsb = `IPR_LSB_ICAP5;
				4'hB:    fld_lsb = `IPR_LSB_ICAP4;
				4'hC:    fld_lsb = `IPR_LSB_ICAP3;
				// Compare 5 word
				4'hD:    fld_lsb = `IPR_LSB_OCMP5;
				// Parallel port word
				default: fld_lsb = `IPR_LSB_PARALLEL_PORT;
			endcase
		end
	endfunction

	// Address decode: bit 3 flags a mapped word, low bits the index
	function [3:0] addr_dec;
		input [ADDR_W-1:0] a;
		begin
			case (a)
				// External interrupt 1 word
				`IPR_OFF_EXT_INT1:        addr_dec = {1'b1, `IPR_IDX_EXT_INT1};
				// Timer 4 and compare 4, 3 word
				`IPR_OFF_TMR4_OC4_OC3:    addr_dec = {1'b1, `IPR_IDX_TMR4_OC4_OC3};
				// Uart 2, external 2 and timer 5 word
				`IPR_OFF_UART2_EXT2_TMR5: addr_dec = {1'b1, `IPR_IDX_UART2_EXT2_TMR5};
				// Spi 2 word
				`IPR_OFF_SPI2:            addr_dec = {1'b1, `IPR_IDX_SPI2};
				// Capture 5, 4, 3 word
				`IPR_OFF_ICAP5_4_3:       addr_dec = {1'b1, `IPR_IDX_ICAP5_4_3};
				// Compare 5 word
				`IPR_OFF_OCMP5:           addr_dec = {1'b1, `IPR_IDX_OCMP5};
				// Parallel port word
				`IPR_OFF_PARALLEL_PORT:   addr_dec = {1'b1, `IPR_IDX_PARALLEL_PORT};
				default:                  addr_dec = 4'h0;
			endcase
		end
	endfunction

	// Implemented bits of each register, the rest never stored or read
	function [15:0] reg_mask;
		input [2:0] ri;
		begin
			case (ri)
				// External interrupt 1 word
				`IPR_IDX_EXT_INT1:        reg_mask = `IPR_MASK_EXT_INT1;
				// Timer 4 and compare 4, 3 word
				`IPR_IDX_TMR4_OC4_OC3:    reg_mask = `IPR_MASK_TMR4_OC4_OC3;
				// Uart 2, external 2 and timer 5 word
				`IPR_IDX_UART2_EXT2_TMR5: reg_mask = `IPR_MASK_UART2_EXT2_TMR5;
				// Spi 2 word
				`IPR_IDX_SPI2:            reg_mask = `IPR_MASK_SPI2;
				// Capture 5, 4, 3 word
				`IPR_IDX_ICAP5_4_3:       reg_mask = `IPR_MASK_ICAP5_4_3;
				// Compare 5 word
				`IPR_IDX_OCMP5:           reg_mask = `IPR_MASK_OCMP5;
				// Parallel port word
				`IPR_IDX_PARALLEL_PORT:   reg_mask = `IPR_MASK_PARALLEL_PORT;
				default:                  reg_mask = 16'h0000;
			endcase
		end
	endfunction

	// Service level of a code, zero means the source is blocked
	function [2:0] prio_level;
		input [2:0] c;
		begin
			case (c)
				// Blocked source
				3'h0:    prio_level = `IPR_PRIO_OFF;
				// Lowest active level
				3'h1:    prio_level = 3'h1;
				// Level two
				3'h2:    prio_level = 3'h2;
				// Level three
				3'h3:    prio_level = 3'h3;
				// Level four, the reset default
				3'h4:    prio_level = 3'h4;
				// Level five
				3'h5:    prio_level = 3'h5;
				// Level six
				3'h6:    prio_level = 3'h6;
				// Highest level
				3'h7:    prio_level = 3'h7;
				default: prio_level = `IPR_PRIO_OFF;
			endcase
		end
	endfunction

	// Field store
	reg  [2:0]  prio_ff [0:`IPR_NUM_FIELDS-1];

	// Bus side state
	reg  [31:0] rdata_ff;
	reg  [31:0] nxt_rdata;
	reg         slverr_ff;

	// Decode and write strobes
	wire [3:0]  dec;
	wire        wr_acc;
	wire [15:0] wr_word;
	wire [6:0]  wr_lo;
	wire [6:0]  wr_hi;
	wire        setup_ph;
	wire        access_ph;
	integer     j;

	// Bus phases and decode of the current address
	assign dec       = addr_dec(PADDR);
	assign setup_ph  = PSEL & ~PENABLE;
	assign access_ph = PSEL & PENABLE;
	assign PREADY    = access_ph;
	assign PRDATA    = rdata_ff;
	assign PSLVERR   = slverr_ff & access_ph;

	// Mapped write in the access phase, unused bits dropped
	assign wr_acc    = access_ph & PWRITE & dec[3];
	assign wr_word   = PWDATA[15:0] & reg_mask(dec[2:0]);

	// Write strobes per register and byte lane
	genvar r;
	generate
		for (r = 0; r < `IPR_NUM_REGS; r = r + 1)
		begin : g_wen
			localparam [2:0] RK = r;
			// Low lane carries bits 7:0
			assign wr_lo[r] = wr_acc & (dec[2:0] == RK) & PSTRB[0];
			// High lane carries bits 15:8
			assign wr_hi[r] = wr_acc & (dec[2:0] == RK) & PSTRB[1];
		end
	endgenerate

	// Read word assembly, unused bits stay zero
	always @*
	begin
		nxt_rdata = 32'h0000_0000;
		// Place each field at its bit position
		for (j = 0; j < `IPR_NUM_FIELDS; j = j + 1)
		begin
			if (fld_reg(j[3:0]) == dec[2:0])
				nxt_rdata[fld_lsb(j[3:0]) +: 3] = prio_ff[j];
		end
		// Mask to implemented bits, zero off the map
		if (~dec[3])
			nxt_rdata = 32'h0000_0000;
		else
			nxt_rdata[15:0] = nxt_rdata[15:0] & reg_mask(dec[2:0]);
	end

	// Read data captured in the setup cycle, zero for a write
	always @(posedge SYS_CLK)
	begin
		if (SYS_RST)
			rdata_ff <= 32'h0000_0000;
		else if (setup_ph)
			rdata_ff <= PWRITE ? 32'h0000_0000 : nxt_rdata;
	end

	// Error for an unmapped word, shown in the access phase
	always @(posedge SYS_CLK)
	begin
		if (SYS_RST)
			slverr_ff <= 1'b0;
		else if (setup_ph)
			slverr_ff <= ~dec[3];
	end

	// One flop group per field, written through its byte lane
	genvar k;
	generate
		for (k = 0; k < `IPR_NUM_FIELDS; k = k + 1)
		begin : g_fld
			// Index, home register, lane and level of this field
			localparam [3:0] FK   = k;
			wire       [3:0] lsb  = fld_lsb(FK);
			wire       [2:0] home = fld_reg(FK);
			wire       [2:0] lvl  = prio_level(prio_ff[k]);
			wire             hit  = lsb[3] ? wr_hi[home] : wr_lo[home];
			// Reset to level four, load on a write to this lane
			always @(posedge SYS_CLK)
			begin
				if (SYS_RST)
					prio_ff[k] <= `IPR_PRIO_RST;
				else if (hit)
					prio_ff[k] <= wr_word[lsb +: 3];
			end
			// Zero code blocks the request whatever the flag says
			assign SRC_REQ[k] = SRC_FLAG[k] & (lvl != `IPR_PRIO_OFF);
		end
	endgenerate

	// Current priority codes for the arbitration logic

	// External interrupt 1 code
	assign EXT_INT1_PRIO      = prio_ff[0];

	// Timer 4 code
	assign TIMER4_PRIO        = prio_ff[1];

	// Compare 4 code
	assign OCMP4_PRIO         = prio_ff[2];

	// Compare 3 code
	assign OCMP3_PRIO         = prio_ff[3];

	// Uart 2 transmit code
	assign UART2_TX_PRIO      = prio_ff[4];

	// Uart 2 receive code
	assign UART2_RX_PRIO      = prio_ff[5];

	// External interrupt 2 code
	assign EXT_INT2_PRIO      = prio_ff[6];

	// Timer 5 code
	assign TIMER5_PRIO        = prio_ff[7];

	// Spi 2 event code
	assign SPI2_EVENT_PRIO    = prio_ff[8];

	// Spi 2 fault code
	assign SPI2_FAULT_PRIO    = prio_ff[9];

	// Capture 5 code
	assign ICAP5_PRIO         = prio_ff[10];

	// Capture 4 code
	assign ICAP4_PRIO         = prio_ff[11];

	// Capture 3 code
	assign ICAP3_PRIO         = prio_ff[12];

	// Compare 5 code
	assign OCMP5_PRIO         = prio_ff[13];

	// Parallel port code
	assign PARALLEL_PORT_PRIO = prio_ff[14];

endmodule // ipr_top

/* File: ipr_chk.sv */
`timescale 1ns/1ps
// Watches the register bank ports
module ipr_chk
(
	input wire        SYS_CLK,
	input wire        SYS_RST,
	input wire        PSEL,
	input wire        PENABLE,
	input wire        PWRITE,
	input wire [11:0] PADDR,
	input wire [31:0] PWDATA,
	input wire [3:0]  PSTRB,
	input wire        PREADY,
	input wire [31:0] PRDATA,
	input wire [14:0] SRC_FLAG,
	input wire [14:0] SRC_REQ,
	input wire [2:0]  EXT_INT1_PRIO,
	input wire [2:0]  TIMER4_PRIO
);
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (SYS_RST);
	// Access phase decode
	wire acc = PSEL && PENABLE;
	wire wr  = acc && PWRITE;
	wire rd  = acc && !PWRITE;
	rdy_now_a: assert property (PREADY == acc) else $error("pready");
	req_gate_a: assert property (SRC_REQ[0] == (SRC_FLAG[0] && EXT_INT1_PRIO != 3'h0))
		else $error("req gate");
	hi_zero_a: assert property (rd |-> PRDATA[31:16] == 16'h0000) else $error("hi");
	ext1_wr_a: assert property (wr && PADDR == 12'h000 && PSTRB[0]
		|=> EXT_INT1_PRIO == $past(PWDATA[2:0])) else $error("ext1 wr");
	tmr4_wr_a: assert property (wr && PADDR == 12'h004 && PSTRB[1]
		|=> TIMER4_PRIO == $past(PWDATA[14:12])) else $error("tmr4 wr");
	ext1_rd_a: assert property (rd && PADDR == 12'h000
		|-> PRDATA[15:0] == {13'h0000, EXT_INT1_PRIO}) else $error("ext1 rd");
	rst_val_a: assert property ($fell(SYS_RST)
		|-> EXT_INT1_PRIO == 3'h4 && TIMER4_PRIO == 3'h4) else $error("rst val");
	field_hold_a: assert property (!wr |=> $stable(EXT_INT1_PRIO)) else $error("hold");
	cover property (wr);
	cover property (rd && PADDR == 12'h004);
	cover property (SRC_FLAG[0] && !SRC_REQ[0]);
endmodule // ipr_chk

/* File: tb.sv */
`timescale 1ns/1ps
`include "ipr_regs.vh"
module tb;
	logic        clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, rdat;
	logic [3:0]  pstrb = 4'hF;
	logic [14:0] flag = 15'h7FFF;
	logic [15:0] msk [7], rstv [7];
	wire         pready, pslverr;
	wire  [31:0] prdata;
	wire  [14:0] req;
	wire  [2:0]  prio0;
	wire  [41:0] pall;
	int          n_fail = 0, check_count = 0;
	ipr_top ipr_top_inst
	(
		.SYS_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PREADY(pready), .PRDATA(prdata),
		.PSLVERR(pslverr), .SRC_FLAG(flag), .SRC_REQ(req), .EXT_INT1_PRIO(prio0),
		.TIMER4_PRIO(pall[2:0]), .OCMP4_PRIO(pall[5:3]), .OCMP3_PRIO(pall[8:6]),
		.UART2_TX_PRIO(pall[11:9]), .UART2_RX_PRIO(pall[14:12]), .EXT_INT2_PRIO(pall[17:15]),
		.TIMER5_PRIO(pall[20:18]), .SPI2_EVENT_PRIO(pall[23:21]), .SPI2_FAULT_PRIO(pall[26:24]),
		.ICAP5_PRIO(pall[29:27]), .ICAP4_PRIO(pall[32:30]), .ICAP3_PRIO(pall[35:33]),
		.OCMP5_PRIO(pall[38:36]), .PARALLEL_PORT_PRIO(pall[41:39])
	);
	// Clock, 8 ns period
	always #4 clk = ~clk;
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("FAIL %s exp %h got %h", nm, e, g);
		end
	endtask
	// One APB transfer, held until pready
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'h1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'h1 && n < 16);
		rdat = prdata;
		err = pslverr;
		if (n >= 16)
		begin
			n_fail++;
			$display("FAIL pready exp 1 got 0");
		end
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic t_reset;
		for (int i = 0; i < 7; i++)
		begin
			apb(12'(i * 4), 1'h0, 32'h0000_0000, 4'hF);
			chk("reset word", {16'h0000, rstv[i]}, rdat);
		end
		chk("prio lo", {11'h000, {7{3'h4}}}, {11'h000, pall[20:0]});
		chk("prio hi", {11'h000, {7{3'h4}}}, {11'h000, pall[41:21]});
		chk("req all", 32'h0000_7FFF, {17'h0_0000, req});
		$display("test reset done");
	endtask
	task automatic t_fill;
		for (int i = 0; i < 7; i++)
		begin
			apb(12'(i * 4), 1'h1, 32'hFFFF_FFFF, 4'hF);
			apb(12'(i * 4), 1'h0, 32'h0000_0000, 4'hF);
			chk("mask", {16'h0000, msk[i]}, rdat);
		end
		chk("ext1 seven", 32'h0000_0007, {29'h0000_0000, prio0});
		chk("fill lo", {11'h000, {7{3'h7}}}, {11'h000, pall[20:0]});
		chk("fill hi", {11'h000, {7{3'h7}}}, {11'h000, pall[41:21]});
		$display("test fill done");
	endtask
	task automatic t_codes;
		for (int c = 7; c >= 0; c--)
		begin
			apb(12'h000, 1'h1, 32'(c), 4'h1);
			@(negedge clk);
			chk("ext1 code", 32'(c), {29'h0000_0000, prio0});
			chk("ext1 req", 32'(c != 0), {31'h0000_0000, req[0]});
		end
		apb(12'h008, 1'h1, 32'h0000_0000, 4'hF);
		@(negedge clk);
		chk("uart2 req", 32'h0000_0000, {28'h000_0000, req[7:4]});
		$display("test codes done");
	endtask
	task automatic t_strobe;
		apb(12'h004, 1'h1, 32'h0000_3333, 4'h1);
		apb(12'h004, 1'h0, 32'h0000_0000, 4'hF);
		chk("lane0 only", 32'h0000_7730, rdat);
		$display("test strobe done");
	endtask
	task automatic t_unmapped;
		apb(12'h01C, 1'h1, 32'hFFFF_FFFF, 4'hF);
		chk("slverr", 32'h0000_0001, {31'h0000_0000, err});
		apb(12'h01C, 1'h0, 32'h0000_0000, 4'hF);
		chk("unmapped rd", 32'h0000_0000, rdat);
		$display("test unmapped done");
	endtask
	task automatic final_report;
		$display("checks %0d fails %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Watchdog
	initial
	begin
		#80000;
		n_fail++;
		final_report();
	end
	// Main sequence
	initial
	begin
		msk = '{`IPR_MASK_EXT_INT1, `IPR_MASK_TMR4_OC4_OC3, `IPR_MASK_UART2_EXT2_TMR5,
			`IPR_MASK_SPI2, `IPR_MASK_ICAP5_4_3, `IPR_MASK_OCMP5, `IPR_MASK_PARALLEL_PORT};
		rstv = '{`IPR_RST_EXT_INT1, `IPR_RST_TMR4_OC4_OC3, `IPR_RST_UART2_EXT2_TMR5,
			`IPR_RST_SPI2, `IPR_RST_ICAP5_4_3, `IPR_RST_OCMP5, `IPR_RST_PARALLEL_PORT};
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		t_reset();
		t_fill();
		t_codes();
		t_strobe();
		t_unmapped();
		rst <= 1'h1;
		@(posedge clk);
		rst <= 1'h0;
		t_reset();
		final_report();
	end
endmodule // tb
bind ipr_top ipr_chk ipr_chk_inst (.*);
